// >>> hdl/dse_cfg.svh
// Constants for the DMA-style serial emulation block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef DSE_CFG_SVH
`define DSE_CFG_SVH

`define DSE_CLK_HZ          125000000
`define DSE_BIT_RATE_HZ     9600
`define DSE_BIT_DIV         (`DSE_CLK_HZ / `DSE_BIT_RATE_HZ)
`define DSE_CNT_W           16
`define DSE_FRAME_BITS      4'hA
`define DSE_FRAME_LAST      4'h9
`define DSE_DATA_BITS       8
`define DSE_MSG_LEN         4'hC
`define DSE_MSG_AW          4
`define DSE_SPI_LAST_BIT    3'h7
`define DSE_RX_LAST_TICK    4'h8
`define DSE_LINE_IDLE       1'b1
`define DSE_START_BIT       1'b0
`define DSE_STOP_BIT        1'b1
`define DSE_TIMER_STOP_VAL  1'b0
`define DSE_TIMER_START_VAL 1'b1
`define DSE_CLK_PATTERN     2'h1

`endif

// >>> hdl/dse_pkg.sv
// Types shared by the serial emulation block.
// Assumes the constants header sits beside this file.
`include "dse_cfg.svh"

package dse_pkg;

	typedef enum logic [1:0] {
		DSE_MODE_TX   = 2'h0,
		DSE_MODE_RX   = 2'h1,
		DSE_MODE_SPIM = 2'h2,
		DSE_MODE_SPIS = 2'h3
	} dse_mode_t;

	typedef enum logic [3:0] {
		DSE_ST_IDLE      = 4'h0,
		DSE_ST_TX_LOAD   = 4'h1,
		DSE_ST_TX_BITS   = 4'h2,
		DSE_ST_TX_STOP   = 4'h3,
		DSE_ST_TX_RELOAD = 4'h4,
		DSE_ST_RX_ARM    = 4'h5,
		DSE_ST_RX_BITS   = 4'h6,
		DSE_ST_SPIM_RUN  = 4'h7,
		DSE_ST_SPIS_RUN  = 4'h8
	} dse_state_t;

	// One write into the message buffer
	typedef struct packed {
		logic                     we;
		logic [`DSE_MSG_AW-1:0]   addr;
		logic [`DSE_DATA_BITS-1:0] data;
	} dse_msg_wr_t;

endpackage

// >>> hdl/dse_top.sv
// Serial link emulation: async transmitter, async receiver, SPI master and slave,
// the first three paced by one bit-period timer, the slave by its sck pin, moving single bits between staging bits and pins.
// Assumes the message write port and start/mode inputs are on clk_i; pins are not.
`timescale 1ns/10ps
`include "dse_cfg.svh"

module dse_top #(
	parameter int BIT_DIV = `DSE_BIT_DIV
) (
	input  wire logic                      clk_i,
	input  wire logic                      sys_rst_i,
	input  wire logic                      clk_en_i,
	input  wire dse_pkg::dse_mode_t        mode_i,
	input  wire logic                      start_i,
	input  wire dse_pkg::dse_msg_wr_t      msg_wr_i,
	input  wire logic [`DSE_DATA_BITS-1:0] spi_tx_i,
	input  wire logic                      rx_pin_i,
	input  wire logic                      spi_sdi_i,
	input  wire logic                      spi_sck_i,
	output logic                           tx_pin_o,
	output logic                           tx_done_o,
	output logic [`DSE_DATA_BITS-1:0]      rx_data_o,
	output logic                           rx_valid_o,
	output logic                           spi_sck_o,
	output logic                           spi_sdo_o,
	output logic [`DSE_DATA_BITS-1:0]      spi_rx_data_o,
	output logic                           spi_done_o,
	output logic                           busy_o
);

	localparam logic [`DSE_CNT_W-1:0] DIV_LAST = `DSE_CNT_W'(BIT_DIV - 1);
	localparam logic [`DSE_CNT_W-1:0] DIV_HALF = `DSE_CNT_W'(BIT_DIV / 2);

	dse_pkg::dse_state_t          state_r;
	logic [`DSE_CNT_W-1:0]        cnt_r;
	logic                         timer_ctrl_r;
	logic [3:0]                   bit_idx_r;
	logic [`DSE_MSG_AW-1:0]       byte_idx_r;
	logic [`DSE_DATA_BITS-1:0]    stage_data_r;
	logic [`DSE_DATA_BITS-1:0]    stage_out_r;
	logic [`DSE_DATA_BITS-1:0]    stage_in_r;
	logic                         phase_r;
	logic [`DSE_DATA_BITS-1:0]    msg_mem [0:(1<<`DSE_MSG_AW)-1];
	logic [2:0]                   rx_sync_r;
	logic [1:0]                   sdi_sync_r;
	logic [2:0]                   sck_sync_r;
	logic                         tx_pin_r;
	logic                         tx_done_r;
	logic [`DSE_DATA_BITS-1:0]    rx_data_r;
	logic                         rx_valid_r;
	logic                         spi_sck_r;
	logic                         spi_sdo_r;
	logic [`DSE_DATA_BITS-1:0]    spi_rx_data_r;
	logic                         spi_done_r;
	logic                         busy_r;

	// Pick one bit of the ten-bit frame; idle level beyond the end
	function automatic logic frame_bit(input logic [`DSE_DATA_BITS-1:0] data,
	                                   input logic [3:0] idx);
		logic [9:0] frame;
		frame = {`DSE_STOP_BIT, data, `DSE_START_BIT};
		if (idx < `DSE_FRAME_BITS)
			frame_bit = frame[idx];
		else
			frame_bit = `DSE_LINE_IDLE;
	endfunction

	// Timer tick and edge decode; only the second and third sync stages are read
	wire                    tick_w     = timer_ctrl_r && (cnt_r == DIV_LAST);
	wire                    rx_fall_w  = rx_sync_r[2] && !rx_sync_r[1];
	wire                    sck_rise_w = sck_sync_r[1] && !sck_sync_r[2];
	wire                    sck_fall_w = sck_sync_r[2] && !sck_sync_r[1];
	wire                    start_w    = start_i && (state_r == dse_pkg::DSE_ST_IDLE);
	wire [1:0]              clk_pat_w  = `DSE_CLK_PATTERN;
	wire                    sck_next_w = clk_pat_w[phase_r];
	wire                    last_byte_w = (byte_idx_r == `DSE_MSG_LEN);
	wire [`DSE_DATA_BITS-1:0] msg_byte_w = msg_mem[byte_idx_r];

	// Message buffer; no reset so it can map onto plain storage
	always_ff @(posedge clk_i) begin
		if (clk_en_i && msg_wr_i.we)
			msg_mem[msg_wr_i.addr] <= msg_wr_i.data;
	end

	// Pin synchronisers, two stages ahead of any logic
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rx_sync_r  <= 3'h7;
			sdi_sync_r <= 2'h0;
			sck_sync_r <= 3'h0;
		end else if (clk_en_i) begin
			rx_sync_r  <= {rx_sync_r[1:0], rx_pin_i};
			sdi_sync_r <= {sdi_sync_r[0], spi_sdi_i};
			sck_sync_r <= {sck_sync_r[1:0], spi_sck_i};
		end
	end

	// Bit-period timer; runs only while its control bit is set
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			cnt_r <= 16'h0000;
		else if (clk_en_i) begin
			if (start_w || (state_r == dse_pkg::DSE_ST_TX_LOAD && !timer_ctrl_r))
				cnt_r <= 16'h0000;
			else if (state_r == dse_pkg::DSE_ST_RX_ARM)
				cnt_r <= DIV_HALF; // Centre the samples in each bit cell
			else if (!timer_ctrl_r || tick_w)
				cnt_r <= 16'h0000;
			else
				cnt_r <= cnt_r + 16'h0001;
		end
	end

	// Sequencer: stands in for the chain of linked channels
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_r       <= dse_pkg::DSE_ST_IDLE;
			timer_ctrl_r  <= `DSE_TIMER_STOP_VAL;
			bit_idx_r     <= 4'h0;
			byte_idx_r    <= 4'h0;
			stage_data_r  <= 8'h00;
			stage_out_r   <= 8'h00;
			stage_in_r    <= 8'h00;
			phase_r       <= 1'b0;
			tx_pin_r      <= `DSE_LINE_IDLE;
			tx_done_r     <= 1'b0;
			rx_data_r     <= 8'h00;
			rx_valid_r    <= 1'b0;
			spi_sck_r     <= 1'b0;
			spi_sdo_r     <= 1'b0;
			spi_rx_data_r <= 8'h00;
			spi_done_r    <= 1'b0;
			busy_r        <= 1'b0;
		end else if (clk_en_i) begin
			tx_done_r  <= 1'b0;
			rx_valid_r <= 1'b0;
			spi_done_r <= 1'b0;
			busy_r     <= (state_r != dse_pkg::DSE_ST_IDLE);
			case (state_r)
				dse_pkg::DSE_ST_IDLE: begin
					if (start_w) begin
						bit_idx_r <= 4'h0;
						phase_r   <= 1'b0;
						case (mode_i)
							dse_pkg::DSE_MODE_TX: begin
								state_r <= dse_pkg::DSE_ST_TX_LOAD;
							end
							dse_pkg::DSE_MODE_RX: begin
								state_r <= dse_pkg::DSE_ST_RX_ARM;
							end
							dse_pkg::DSE_MODE_SPIM: begin
								stage_out_r  <= spi_tx_i;
								timer_ctrl_r <= `DSE_TIMER_START_VAL;
								state_r      <= dse_pkg::DSE_ST_SPIM_RUN;
							end
							default: begin
								stage_out_r <= spi_tx_i;
								state_r     <= dse_pkg::DSE_ST_SPIS_RUN;
							end
						endcase
					end
				end
				dse_pkg::DSE_ST_TX_LOAD: begin
					// Next byte into the staging data bits
					stage_data_r <= msg_byte_w;
					byte_idx_r   <= byte_idx_r + 4'h1;
					bit_idx_r    <= 4'h0;
					timer_ctrl_r <= `DSE_TIMER_START_VAL;
					state_r      <= dse_pkg::DSE_ST_TX_BITS;
				end
				dse_pkg::DSE_ST_TX_BITS: begin
					if (tick_w) begin
						tx_pin_r <= frame_bit(stage_data_r, bit_idx_r);
						if (bit_idx_r == `DSE_FRAME_LAST)
							state_r <= last_byte_w ? dse_pkg::DSE_ST_TX_STOP
							                       : dse_pkg::DSE_ST_TX_LOAD;
						else
							bit_idx_r <= bit_idx_r + 4'h1;
					end
				end
				dse_pkg::DSE_ST_TX_STOP: begin
					// Stop bit is already on the pin, so halting here loses nothing
					timer_ctrl_r <= `DSE_TIMER_STOP_VAL;
					state_r      <= dse_pkg::DSE_ST_TX_RELOAD;
				end
				dse_pkg::DSE_ST_TX_RELOAD: begin
					byte_idx_r <= 4'h0;
					tx_done_r  <= 1'b1;
					state_r    <= dse_pkg::DSE_ST_IDLE;
				end
				dse_pkg::DSE_ST_RX_ARM: begin
					if (rx_fall_w) begin
						timer_ctrl_r <= `DSE_TIMER_START_VAL;
						bit_idx_r    <= 4'h0;
						state_r      <= dse_pkg::DSE_ST_RX_BITS;
					end
				end
				dse_pkg::DSE_ST_RX_BITS: begin
					if (tick_w) begin
						bit_idx_r <= bit_idx_r + 4'h1;
						// First tick lands on the start bit and is dropped
						if (bit_idx_r != 4'h0)
							stage_data_r <= {rx_sync_r[2], stage_data_r[7:1]};
						if (bit_idx_r == `DSE_RX_LAST_TICK) begin
							timer_ctrl_r <= `DSE_TIMER_STOP_VAL;
							rx_data_r    <= {rx_sync_r[2], stage_data_r[7:1]};
							rx_valid_r   <= 1'b1;
							state_r      <= dse_pkg::DSE_ST_IDLE;
						end
					end
				end
				dse_pkg::DSE_ST_SPIM_RUN: begin
					if (tick_w) begin
						spi_sck_r <= sck_next_w;
						phase_r   <= ~phase_r;
						if (!phase_r) begin
							// Leading edge drives out
							spi_sdo_r   <= stage_out_r[7];
							stage_out_r <= {stage_out_r[6:0], 1'b0};
						end else begin
							// Trailing edge samples in
							stage_in_r <= {stage_in_r[6:0], sdi_sync_r[1]};
							bit_idx_r  <= bit_idx_r + 4'h1;
							if (bit_idx_r[2:0] == `DSE_SPI_LAST_BIT) begin
								timer_ctrl_r  <= `DSE_TIMER_STOP_VAL;
								spi_rx_data_r <= {stage_in_r[6:0], sdi_sync_r[1]};
								spi_done_r    <= 1'b1;
								state_r       <= dse_pkg::DSE_ST_IDLE;
							end
						end
					end
				end
				dse_pkg::DSE_ST_SPIS_RUN: begin
					if (sck_rise_w) begin
						spi_sdo_r   <= stage_out_r[7];
						stage_out_r <= {stage_out_r[6:0], 1'b0};
					end else if (sck_fall_w) begin
						stage_in_r <= {stage_in_r[6:0], sdi_sync_r[1]};
						bit_idx_r  <= bit_idx_r + 4'h1;
						if (bit_idx_r[2:0] == `DSE_SPI_LAST_BIT) begin
							spi_rx_data_r <= {stage_in_r[6:0], sdi_sync_r[1]};
							spi_done_r    <= 1'b1;
							state_r       <= dse_pkg::DSE_ST_IDLE;
						end
					end
				end
				default: begin
					timer_ctrl_r <= `DSE_TIMER_STOP_VAL;
					state_r      <= dse_pkg::DSE_ST_IDLE;
				end
			endcase
		end
	end

	// Outputs straight from flops
	assign tx_pin_o      = tx_pin_r;
	assign tx_done_o     = tx_done_r;
	assign rx_data_o     = rx_data_r;
	assign rx_valid_o    = rx_valid_r;
	assign spi_sck_o     = spi_sck_r;
	assign spi_sdo_o     = spi_sdo_r;
	assign spi_rx_data_o = spi_rx_data_r;
	assign spi_done_o    = spi_done_r;
	assign busy_o        = busy_r;

endmodule

// >>> verif/dse_assertions.sv
// Port checker for the serial emulation block.
// Assumes clk_en_i stays high while frames run.
`timescale 1ns/10ps
`include "dse_cfg.svh"
module dse_assertions #(
	parameter int BIT_DIV = `DSE_BIT_DIV
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	input wire logic tx_pin_o,
	input wire logic tx_done_o,
	input wire logic rx_valid_o,
	input wire logic spi_sck_o,
	input wire logic spi_done_o,
	input wire logic busy_o
);
	logic last_r;
	logic in_r;
	int   run_r;
	int   hi_r;
	wire  chg = tx_pin_o != last_r;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);

	// Level run length; first edge of a message only arms the check
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			last_r <= 1'h1;
			in_r   <= 1'h0;
			run_r  <= 0;
			hi_r   <= 0;
		end else if (clk_en_i) begin
			last_r <= tx_pin_o;
			in_r   <= busy_o && (in_r || chg);
			run_r  <= chg ? 0 : run_r + 1;
			hi_r   <= spi_sck_o ? hi_r + 1 : 0; // Counted, as the real divider is far too long
		end
	end

	// Edges in a message land on whole bit periods
	a_bit_len_whole: assert property (chg && in_r |-> (run_r + 1) % BIT_DIV == 0)
		else $error("tx bit length off");
	a_tx_idle_high: assert property (!busy_o |-> tx_pin_o)
		else $error("tx pin low while idle");
	a_sck_rest_low: assert property (!busy_o |-> !spi_sck_o)
		else $error("sck high while idle");
	a_sck_half_len: assert property ($fell(spi_sck_o) |-> hi_r == BIT_DIV)
		else $error("sck high phase wrong");
	a_sck_high_max: assert property (spi_sck_o |-> hi_r < BIT_DIV)
		else $error("sck high too long");
	a_done_one_cycle: assert property (tx_done_o |=> !tx_done_o)
		else $error("tx done too long");
	a_done_then_idle: assert property (tx_done_o |-> tx_pin_o ##[1:4] !busy_o)
		else $error("tx not stopped");
	a_rx_one_cycle: assert property (rx_valid_o |=> !rx_valid_o)
		else $error("rx valid too long");
	a_spi_end_quiet: assert property (spi_done_o |-> !spi_sck_o ##1 !spi_done_o)
		else $error("spi end wrong");
	a_spi_timer_off: assert property (spi_done_o |=> $stable(spi_sck_o) [*8])
		else $error("sck moves after done");
endmodule

bind dse_top dse_assertions #(.BIT_DIV(BIT_DIV)) dse_assertions_inst (.clk_i, .sys_rst_i,
	.clk_en_i, .tx_pin_o, .tx_done_o, .rx_valid_o, .spi_sck_o, .spi_done_o, .busy_o);

// >>> verif/dse_peer.sv
// SPI slave peer, clock phase 1 and polarity 0, MSB first.
// Assumes the master rests its clock low.
// No chip select here: software owns that line
`timescale 1ns/10ps
module dse_peer (
	input  wire logic       sck_i,
	input  wire logic       mosi_i,
	input  wire logic [7:0] tx_i,
	output logic            miso_o,
	output logic [7:0]      rx_o
);
	int n = 0;

	initial begin
		miso_o = 1'h0;
		rx_o   = 8'h00;
	end
	// Leading edge launches the next bit
	always @(posedge sck_i) begin
		miso_o <= tx_i[7 - n];
	end
	// Trailing edge captures; line flips after a byte so stale data never passes
	always @(negedge sck_i) begin
		rx_o <= {rx_o[6:0], mosi_i};
		n = (n + 1) % 8;
		if (n == 0) begin
			miso_o <= ~miso_o;
		end
	end
endmodule

// >>> verif/tb.sv
// Bench: two messages out, received frames, SPI master bytes.
// Assumes a short bit period to keep the run brief.
`timescale 1ns/10ps
module tb;
	localparam int BD = 16;
	logic                 clk_i, sys_rst_i, start_i, rx_pin_i, spi_sdi_i;
	logic                 tx_pin_o, tx_done_o, rx_valid_o, spi_sck_o, spi_sdo_o;
	logic                 spi_done_o, busy_o;
	logic                 slv = 1'h0, sck_tb = 1'h0, mosi_tb = 1'h0, peer_miso;
	logic [7:0]           got;
	logic [7:0]           spi_tx_i, peer_tx, peer_rx, rx_data_o, spi_rx_data_o, d;
	logic [7:0]           msg [12];
	dse_pkg::dse_mode_t   mode_i;
	dse_pkg::dse_msg_wr_t msg_wr_i;
	logic [31:0]          seed = 32'h0000ECA3;
	int                   miscompares = 0, samples_checked = 0, n;
	int                   rx_cnt = 0, done_cnt = 0, sck_cnt = 0;

	dse_top #(.BIT_DIV(BD)) dse_top_inst (.clk_i, .sys_rst_i, .clk_en_i(1'h1), .mode_i,
		.start_i, .msg_wr_i, .spi_tx_i, .rx_pin_i, .spi_sdi_i, .spi_sck_i(sck_tb), .tx_pin_o,
		.tx_done_o, .rx_data_o, .rx_valid_o, .spi_sck_o, .spi_sdo_o, .spi_rx_data_o,
		.spi_done_o, .busy_o);
	dse_peer dse_peer_inst (.sck_i(spi_sck_o), .mosi_i(spi_sdo_o), .tx_i(peer_tx),
		.miso_o(peer_miso), .rx_o(peer_rx));
	// Bench plays master in slave mode, so it owns the data-in line then
	assign spi_sdi_i = slv ? mosi_tb : peer_miso;

	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	// Line level of bit b of a frame
	function automatic logic fbit(logic [7:0] v, int b);
		return (b == 0) ? 1'h0 : (b == 9) ? 1'h1 : v[b-1];
	endfunction
	task automatic chk(string what, logic [9:0] seen, logic [9:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic go(dse_pkg::dse_mode_t m);
		mode_i = m;
		start_i = 1'h1;
		@(negedge clk_i);
		start_i = 1'h0;
	endtask

	initial begin
		clk_i = 1'h0;
		forever #4 clk_i = ~clk_i;
	end
	// Pulses counted mid-cycle, where they are settled
	always @(negedge clk_i) begin
		rx_cnt += int'(rx_valid_o === 1'h1);
		done_cnt += int'(tx_done_o === 1'h1);
	end
	always @(posedge spi_sck_o) sck_cnt++;
	initial begin
		repeat (30000) @(posedge clk_i);
		miscompares++;
		end_sim();
	end

	initial begin
		sys_rst_i = 1'h1;
		start_i = 1'h0;
		rx_pin_i = 1'h1;
		mode_i = dse_pkg::DSE_MODE_TX;
		msg_wr_i = '0;
		spi_tx_i = 8'h00;
		peer_tx = 8'h00;
		repeat (5) @(negedge clk_i);
		sys_rst_i = 1'h0;
		// Second message proves the byte pointer came back; a stray start is ignored
		for (int r = 0; r < 2; r++) begin
			for (int i = 0; i < 12; i++) begin
				// Buffer filled from address 0; descriptor alignment is software's job
				msg[i] = (i == 0) ? 8'h00 : (i == 11) ? 8'hFF : rnd();
				msg_wr_i = '{1'h1, 4'(i), msg[i]};
				@(negedge clk_i);
			end
			msg_wr_i.we = 1'h0;
			go(dse_pkg::DSE_MODE_TX);
			for (int i = 0; i < 12; i++) begin
				// Frames run back to back, so only the first start bit is searched for
				if (i == 0) begin
					for (n = 0; n < 3 * BD && tx_pin_o !== 1'h0; n++) @(negedge clk_i);
					repeat (BD / 2) @(negedge clk_i);
				end
				for (int b = 0; b < 10; b++) begin
					chk("tx bit", tx_pin_o, fbit(msg[i], b));
					start_i = (i == 5 && b == 1);
					repeat (BD) @(negedge clk_i);
				end
			end
			repeat (2 * BD) @(negedge clk_i);
			chk("tx end", {busy_o, tx_pin_o, 8'(done_cnt)}, {2'h1, 8'(r + 1)});
			$display("tx message %0d done", r);
		end
		// A fall before arming is ignored
		rx_pin_i = 1'h0;
		repeat (BD) @(negedge clk_i);
		rx_pin_i = 1'h1;
		repeat (BD) @(negedge clk_i);
		chk("rx unarmed", {busy_o, 8'(rx_cnt)}, 10'h000);
		for (int k = 0; k < 4; k++) begin
			d = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : rnd();
			go(dse_pkg::DSE_MODE_RX);
			repeat (3) @(negedge clk_i);
			for (int b = 0; b < 10; b++) begin
				rx_pin_i = fbit(d, b);
				repeat (BD) @(negedge clk_i);
			end
			chk("rx byte", {rx_data_o, 2'(rx_cnt - k)}, {d, 2'h1});
		end
		$display("rx test done");
		for (int k = 0; k < 4; k++) begin
			spi_tx_i = (k == 0) ? 8'h81 : rnd();
			peer_tx = (k == 1) ? 8'h7E : rnd();
			sck_cnt = 0;
			go(dse_pkg::DSE_MODE_SPIM);
			for (n = 0; n < 20 * BD && spi_done_o !== 1'h1; n++) @(negedge clk_i);
			chk("spi in", spi_rx_data_o, peer_tx);
			chk("spi out", peer_rx, spi_tx_i);
			repeat (BD) @(negedge clk_i);
			chk("spi end", {busy_o, spi_sck_o, 8'(sck_cnt)}, 10'h008);
		end
		$display("spi test done");
		// Slave mode: bench moves data on the rising clock edge, samples on the falling one
		slv = 1'h1;
		for (int k = 0; k < 3; k++) begin
			spi_tx_i = (k == 0) ? 8'hA5 : rnd();
			d = (k == 1) ? 8'h3C : rnd();
			go(dse_pkg::DSE_MODE_SPIS);
			for (int b = 0; b < 8; b++) begin
				sck_tb = 1'h1;
				mosi_tb = d[7 - b];
				repeat (8) @(negedge clk_i);
				got = {got[6:0], spi_sdo_o};
				sck_tb = 1'h0;
				repeat (8) @(negedge clk_i);
			end
			chk("spis in", {busy_o, spi_sck_o, spi_rx_data_o}, {2'h0, d});
			chk("spis out", got, spi_tx_i);
		end
		slv = 1'h0;
		$display("spi slave test done");
		end_sim();
	end
endmodule
